// *** include/etr_cfg.svh ***
// constants for the elapsed-time recorder configuration and serial port
`ifndef ETR_CFG_SVH
`define ETR_CFG_SVH
`define ETR_CLK_MHZ 250
`define ETR_PULSE_LOW_US 62500
`define ETR_PULSE_HIGH_US 437500
`define ETR_PULSE_COUNT 3'h4
`define ETR_SLAVE_ADDR 7'h50
`define ETR_A_CFG 5'h00
`define ETR_A_TRIP 5'h01
`define ETR_A_ACC 5'h05
`define ETR_A_EVT 5'h09
`define ETR_A_USR 5'h0b
`define ETR_A_USR_END 5'h14
`define ETR_A_CLR 5'h1d
`define ETR_A_CORE 5'h1e
`define ETR_A_ULOCK 5'h1f
`define ETR_CODE_CLR 8'h55
`define ETR_CODE_CORE 8'haa
`define ETR_CODE_USER 8'hf0
`define ETR_B_AOR 7
`define ETR_B_AF 6
`define ETR_B_WDF 5
`define ETR_B_USER_MEMORY_LOCK_FLAG 4
`define ETR_B_AOS 3
`define ETR_B_RE 2
`define ETR_B_AP 1
`define ETR_B_ERO 0
`define ETR_EVT_FULL 16'hffff
`define ETR_USR_N 10
`endif

// *** include/etr_pkg.sv ***
// types for the elapsed-time recorder serial port
package etr_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_AACK = 4'h2,
        ST_PTR = 4'h3,
        ST_PACK = 4'h4,
        ST_WR = 4'h5,
        ST_WACK = 4'h6,
        ST_RD = 4'h7,
        ST_RACK = 4'h8
    } etr_state_e;
    typedef logic [7:0] etr_byte_t;
endpackage

// *** core/etr_top.sv ***
// configuration, lock, user memory and two-wire slave of the recorder
`timescale 1ns/10ps
`include "etr_cfg.svh"
module etr_top #(
    parameter int PULSE_LOW_CYC = `ETR_PULSE_LOW_US * `ETR_CLK_MHZ,
    parameter int PULSE_HIGH_CYC = `ETR_PULSE_HIGH_US * `ETR_CLK_MHZ
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_alarm_pin,
    output logic o_alarm_out,
    output logic o_alarm_oe,
    input wire logic i_event_end,
    input wire logic [31:0] i_accum_value,
    output logic [31:0] o_accum,
    output logic [15:0] o_event_count,
    output logic o_alarm_active,
    output logic o_clear
);
    etr_pkg::etr_state_e state;
    logic [2:0] scl_s, sda_s, pin_s;
    logic scl_f, sda_f, pin_f, scl_q, sda_q, pin_q;
    logic scl_rise, scl_fall, start_c, stop_c;
    logic [2:0] bit_cnt;
    logic done, rw, nack, match;
    logic [7:0] sh, tx, rd_val;
    logic [4:0] ptr, wr_addr;
    logic [7:0] wr_data;
    logic wr_go;
    logic [7:0] cfg;
    logic event_count_overflow, core_lock_flag, user_memory_lock_flag, core_step, user_step;
    logic [31:0] trip;
    logic [7:0] user_mem [0:`ETR_USR_N-1];
    logic permit, clr_go, core_ok, user_ok;
    logic alarm_now, init_trig, ext_low, rel_trig, trig;
    logic [2:0] p_left;
    logic p_low;
    logic [31:0] tmr;
    logic [3:0] oe_hist;

    function automatic logic in_rng(input logic [4:0] a,
                                    input logic [4:0] lo,
                                    input logic [4:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    // three-stage sampling; change taken when stages two and three agree
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            pin_s <= 3'h7;
        end else begin
            scl_s <= {scl_s[1:0], i_scl};
            sda_s <= {sda_s[1:0], i_sda};
            pin_s <= {pin_s[1:0], i_alarm_pin};
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            pin_f <= 1'b1;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            pin_q <= 1'b1;
        end else begin
            if (scl_s[1] == scl_s[2]) begin
                scl_f <= scl_s[2];
            end
            if (sda_s[1] == sda_s[2]) begin
                sda_f <= sda_s[2];
            end
            if (pin_s[1] == pin_s[2]) begin
                pin_f <= pin_s[2];
            end
            scl_q <= scl_f;
            sda_q <= sda_f;
            pin_q <= pin_f;
        end
    end

    assign scl_rise = scl_f & ~scl_q;
    assign scl_fall = ~scl_f & scl_q;
    assign start_c = scl_f & scl_q & sda_q & ~sda_f;
    assign stop_c = scl_f & scl_q & ~sda_q & sda_f;
    assign match = (sh[7:1] == `ETR_SLAVE_ADDR);

    // read mux; lock and clear locations read zero
    always_comb begin
        rd_val = 8'h00;
        if (ptr == `ETR_A_CFG) begin
            rd_val = {cfg[`ETR_B_AOR], o_alarm_active, core_lock_flag, user_memory_lock_flag,
                      cfg[`ETR_B_AOS], cfg[`ETR_B_RE], cfg[`ETR_B_AP], event_count_overflow};
        end else if (in_rng(ptr, `ETR_A_TRIP, `ETR_A_TRIP + 5'h3)) begin
            rd_val = trip[8*(ptr-`ETR_A_TRIP) +: 8];
        end else if (in_rng(ptr, `ETR_A_ACC, `ETR_A_ACC + 5'h3)) begin
            rd_val = o_accum[8*(ptr-`ETR_A_ACC) +: 8];
        end else if (in_rng(ptr, `ETR_A_EVT, `ETR_A_EVT + 5'h1)) begin
            rd_val = o_event_count[8*(ptr-`ETR_A_EVT) +: 8];
        end else if (in_rng(ptr, `ETR_A_USR, `ETR_A_USR_END)) begin
            rd_val = user_mem[4'(ptr - `ETR_A_USR)];
        end
    end

    // slave-only serial engine: samples on clock rise, drives on fall
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= etr_pkg::ST_IDLE;
            bit_cnt <= 3'h0;
            done <= 1'b0;
            rw <= 1'b0;
            nack <= 1'b0;
            sh <= 8'h00;
            tx <= 8'h00;
            ptr <= 5'h00;
            o_sda_oe <= 1'b0;
            wr_go <= 1'b0;
            wr_addr <= 5'h00;
            wr_data <= 8'h00;
        end else begin
            wr_go <= 1'b0;
            if (start_c) begin
                state <= etr_pkg::ST_ADDR;
                bit_cnt <= 3'h0;
                done <= 1'b0;
                o_sda_oe <= 1'b0;
            end else if (stop_c) begin
                state <= etr_pkg::ST_IDLE;
                o_sda_oe <= 1'b0;
            end else if (scl_rise) begin
                case (state)
                    etr_pkg::ST_ADDR, etr_pkg::ST_PTR, etr_pkg::ST_WR: begin
                        sh <= {sh[6:0], sda_f};
                        bit_cnt <= bit_cnt + 3'h1;
                        done <= (bit_cnt == 3'h7);
                    end
                    etr_pkg::ST_RD: begin
                        bit_cnt <= bit_cnt + 3'h1;
                        done <= (bit_cnt == 3'h7);
                    end
                    etr_pkg::ST_RACK: begin
                        nack <= sda_f;
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                case (state)
                    etr_pkg::ST_ADDR: begin
                        if (done) begin
                            done <= 1'b0;
                            if (match) begin
                                rw <= sh[0];
                                o_sda_oe <= 1'b1;
                                state <= etr_pkg::ST_AACK;
                            end else begin
                                state <= etr_pkg::ST_IDLE;
                            end
                        end
                    end
                    etr_pkg::ST_AACK: begin
                        if (rw) begin
                            tx <= rd_val;
                            o_sda_oe <= ~rd_val[7];
                            ptr <= ptr + 5'h1;
                            state <= etr_pkg::ST_RD;
                        end else begin
                            o_sda_oe <= 1'b0;
                            state <= etr_pkg::ST_PTR;
                        end
                    end
                    etr_pkg::ST_PTR: begin
                        if (done) begin
                            done <= 1'b0;
                            ptr <= sh[4:0];
                            o_sda_oe <= 1'b1;
                            state <= etr_pkg::ST_PACK;
                        end
                    end
                    etr_pkg::ST_WR: begin
                        if (done) begin
                            done <= 1'b0;
                            wr_go <= 1'b1;
                            wr_addr <= ptr;
                            wr_data <= sh;
                            ptr <= ptr + 5'h1;
                            o_sda_oe <= 1'b1;
                            state <= etr_pkg::ST_WACK;
                        end
                    end
                    etr_pkg::ST_PACK, etr_pkg::ST_WACK: begin
                        o_sda_oe <= 1'b0;
                        state <= etr_pkg::ST_WR;
                    end
                    etr_pkg::ST_RD: begin
                        if (done) begin
                            done <= 1'b0;
                            o_sda_oe <= 1'b0;
                            state <= etr_pkg::ST_RACK;
                        end else begin
                            tx <= {tx[6:0], 1'b0};
                            o_sda_oe <= ~tx[6];
                        end
                    end
                    etr_pkg::ST_RACK: begin
                        if (nack) begin
                            o_sda_oe <= 1'b0;
                            state <= etr_pkg::ST_IDLE;
                        end else begin
                            tx <= rd_val;
                            o_sda_oe <= ~rd_val[7];
                            ptr <= ptr + 5'h1;
                            state <= etr_pkg::ST_RD;
                        end
                    end
                    default: begin
                        o_sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign o_sda_out = 1'b0;
    assign permit = cfg[`ETR_B_RE] | (cfg[`ETR_B_AOR] & pin_f);
    assign clr_go = wr_go && (wr_addr == `ETR_A_CLR)
                    && (wr_data == `ETR_CODE_CLR)
                    && permit && !core_lock_flag;
    assign core_ok = wr_go && !core_lock_flag;
    assign user_ok = wr_go && !user_memory_lock_flag;

    // two-write lock sequences; any other write restarts them
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            core_lock_flag <= 1'b0;
            user_memory_lock_flag <= 1'b0;
            core_step <= 1'b0;
            user_step <= 1'b0;
        end else if (wr_go) begin
            core_step <= (wr_addr == `ETR_A_CORE)
                         && (wr_data == `ETR_CODE_CORE);
            user_step <= (wr_addr == `ETR_A_ULOCK)
                         && (wr_data == `ETR_CODE_USER);
            if (core_step && wr_addr == `ETR_A_CORE
                && wr_data == `ETR_CODE_CORE) begin
                core_lock_flag <= 1'b1;
            end
            if (user_step && wr_addr == `ETR_A_ULOCK
                && wr_data == `ETR_CODE_USER) begin
                user_memory_lock_flag <= 1'b1;
            end
        end
    end

    // configuration and trip point
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cfg <= 8'h00;
            trip <= 32'h0000_0000;
        end else if (core_ok) begin
            if (wr_addr == `ETR_A_CFG) begin
                cfg[`ETR_B_AOR] <= wr_data[`ETR_B_AOR];
                cfg[`ETR_B_AOS] <= wr_data[`ETR_B_AOS];
                cfg[`ETR_B_RE] <= wr_data[`ETR_B_RE];
                cfg[`ETR_B_AP] <= wr_data[`ETR_B_AP];
            end
            if (in_rng(wr_addr, `ETR_A_TRIP, `ETR_A_TRIP + 5'h3)) begin
                trip[8*(wr_addr-`ETR_A_TRIP) +: 8] <= wr_data;
            end
        end
    end

    // total time accumulator
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_accum <= 32'h0000_0000;
        end else if (clr_go) begin
            o_accum <= 32'h0000_0000;
        end else if (core_ok
                     && in_rng(wr_addr, `ETR_A_ACC, `ETR_A_ACC + 5'h3)) begin
            o_accum[8*(wr_addr-`ETR_A_ACC) +: 8] <= wr_data;
        end else if (i_event_end) begin
            o_accum <= i_accum_value;
        end
    end

    // event counter with overflow bit as seventeenth bit
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_event_count <= 16'h0000;
            event_count_overflow <= 1'b0;
        end else if (clr_go) begin
            o_event_count <= 16'h0000;
            event_count_overflow <= 1'b0;
        end else begin
            if (core_ok
                && in_rng(wr_addr, `ETR_A_EVT, `ETR_A_EVT + 5'h1)) begin
                o_event_count[8*(wr_addr-`ETR_A_EVT) +: 8] <= wr_data;
            end else if (i_event_end) begin
                if (o_event_count != `ETR_EVT_FULL) begin
                    o_event_count <= o_event_count + 16'h0001;
                end else if (!event_count_overflow) begin
                    event_count_overflow <= 1'b1;
                    o_event_count <= 16'h0000;
                end
            end
            // a config write takes the overflow bit; events still count
            if (core_ok && (wr_addr == `ETR_A_CFG)) begin
                event_count_overflow <= wr_data[`ETR_B_ERO];
            end
        end
    end

    // user memory
    always_ff @(posedge i_clk_sys) begin
        if (user_ok && in_rng(wr_addr, `ETR_A_USR, `ETR_A_USR_END)) begin
            user_mem[4'(wr_addr - `ETR_A_USR)] <= wr_data;
        end
    end

    // clear strobe for the elapsed count outside
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_clear <= 1'b0;
        end else begin
            o_clear <= clr_go;
        end
    end

    // alarm comparison against the trip point
    assign alarm_now = cfg[`ETR_B_AP] ? (o_accum >= trip)
                                      : (o_accum < trip);

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_alarm_active <= 1'b0;
        end else begin
            o_alarm_active <= alarm_now;
        end
    end

    // trigger sources for the pulsed style
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            init_trig <= 1'b1;
            ext_low <= 1'b0;
            oe_hist <= 4'h0;
        end else begin
            init_trig <= 1'b0;
            oe_hist <= {oe_hist[2:0], o_alarm_oe};
            if (!pin_f && !o_alarm_oe && oe_hist == 4'h0) begin
                ext_low <= 1'b1;
            end else if (pin_f) begin
                ext_low <= 1'b0;
            end
        end
    end

    assign rel_trig = ext_low & pin_f & ~pin_q;
    assign trig = init_trig | rel_trig | (alarm_now & ~o_alarm_active);

    // four-pulse generator
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            p_left <= 3'h0;
            p_low <= 1'b0;
            tmr <= 32'h0000_0000;
        end else if (trig && cfg[`ETR_B_AOS] && !cfg[`ETR_B_AOR]) begin
            p_left <= `ETR_PULSE_COUNT;
            p_low <= 1'b1;
            tmr <= 32'h0000_0000;
        end else if (p_left != 3'h0) begin
            tmr <= tmr + 32'h0000_0001;
            if (p_low && tmr == 32'(PULSE_LOW_CYC - 1)) begin
                p_low <= 1'b0;
                tmr <= 32'h0000_0000;
            end else if (!p_low && tmr == 32'(PULSE_HIGH_CYC - 1)) begin
                p_left <= p_left - 3'h1;
                p_low <= (p_left != 3'h1);
                tmr <= 32'h0000_0000;
            end
        end
    end

    // alarm pin drive; pin is an input when mapped to clear permit
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_alarm_oe <= 1'b0;
        end else if (cfg[`ETR_B_AOR]) begin
            o_alarm_oe <= 1'b0;
        end else if (cfg[`ETR_B_AOS]) begin
            o_alarm_oe <= p_low && (p_left != 3'h0);
        end else begin
            o_alarm_oe <= alarm_now;
        end
    end

    assign o_alarm_out = 1'b0;
endmodule

// *** sim/etr_top_asserts.sv ***
// concurrent checks on the recorder port pins
`timescale 1ns/10ps
module etr_top_asserts #(
    parameter int PULSE_LOW_CYC = 8,
    parameter int PULSE_HIGH_CYC = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    input wire logic i_alarm_pin,
    input wire logic o_alarm_out,
    input wire logic o_alarm_oe,
    input wire logic i_event_end,
    input wire logic [31:0] i_accum_value,
    input wire logic [31:0] o_accum,
    input wire logic [15:0] o_event_count,
    input wire logic o_alarm_active,
    input wire logic o_clear
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);
    sequence bus_start;
        i_scl && $fell(i_sda);
    endsequence
    sequence bus_stop;
        i_scl && $rose(i_sda);
    endsequence
    sda_value_a: assert property (o_sda_out == 1'b0)
        else $error("sda drive value not low");
    alarm_value_a: assert property (o_alarm_out == 1'b0)
        else $error("alarm drive value not low");
    clear_pulse_a: assert property (o_clear |=> !o_clear)
        else $error("clear pulse longer than one cycle");
    clear_zero_a: assert property (o_clear |-> ##[0:2]
        (o_accum == 32'h0 && o_event_count == 16'h0))
        else $error("clear left counters non-zero");
    count_step_a: assert property (i_event_end && !o_clear
        && o_event_count != 16'hffff
        |=> o_event_count == $past(o_event_count) + 16'h1)
        else $error("event count did not step by one");
    count_full_a: assert property (i_event_end
        && o_event_count == 16'hffff
        |=> o_event_count inside {16'h0000, 16'hffff})
        else $error("full event count moved wrongly");
    start_quiet_a: assert property (bus_start |=> !o_sda_oe [*8])
        else $error("data pulled low right after start");
    stop_quiet_a: assert property (bus_stop |=> !o_sda_oe [*8])
        else $error("data pulled low right after stop");
endmodule

// *** sim/etr_master.sv ***
// two-wire bus master model driving clock and data
`timescale 1ns/10ps
module etr_master (
    input wire logic i_clk,
    output logic o_scl,
    output logic o_sda_low,
    input wire logic i_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic wait_q(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic clk_bit(input logic b, output logic r);
        wait_q(4);
        o_sda_low <= ~b;
        wait_q(4);
        o_scl <= 1'b1;
        wait_q(7);
        @(negedge i_clk) r = i_sda;
        @(posedge i_clk) o_scl <= 1'b0;
    endtask
    task automatic start();
        wait_q(4);
        o_sda_low <= 1'b0;
        wait_q(4);
        o_scl <= 1'b1;
        wait_q(4);
        o_sda_low <= 1'b1;
        wait_q(4);
        o_scl <= 1'b0;
    endtask
    task automatic stop();
        wait_q(4);
        o_sda_low <= 1'b1;
        wait_q(4);
        o_scl <= 1'b1;
        wait_q(4);
        o_sda_low <= 1'b0;
        wait_q(16);
        @(negedge i_clk);
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], r);
        end
        clk_bit(1'b1, ack);
    endtask
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, r);
            d[i] = r;
        end
        clk_bit(last, r);
    endtask
endmodule

// *** sim/etr_top_bench.sv ***
// self-checking bench for the recorder configuration port
`timescale 1ns/10ps
`include "etr_cfg.svh"
module etr_top_bench;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic ev_end = 1'b0;
    logic [31:0] acc_in = 32'h0;
    logic scl, m_low, sda, sda_out, sda_oe, alarm_pin, alarm_out, alarm_oe;
    logic alarm_act, clr;
    logic [31:0] accum;
    logic [15:0] evt_cnt;
    int error_cnt = 0;
    int n_checks = 0;
    int oe_rises = 0;
    always #2 clk_sys = ~clk_sys;
    always @(posedge alarm_oe) oe_rises++;
    assign sda = ~(m_low | sda_oe);
    assign alarm_pin = ~alarm_oe;
    etr_top #(.PULSE_LOW_CYC(8), .PULSE_HIGH_CYC(16)) etr_top_i (
        .i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_scl(scl),
        .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
        .i_alarm_pin(alarm_pin), .o_alarm_out(alarm_out),
        .o_alarm_oe(alarm_oe), .i_event_end(ev_end),
        .i_accum_value(acc_in), .o_accum(accum),
        .o_event_count(evt_cnt), .o_alarm_active(alarm_act),
        .o_clear(clr));
    etr_master etr_master_i (.i_clk(clk_sys), .o_scl(scl),
        .o_sda_low(m_low), .i_sda(sda));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic put(input etr_pkg::etr_byte_t b);
        logic ack;
        etr_master_i.wr_byte(b, ack);
        check(ack, 1'b0);
    endtask
    task automatic wr(input logic [4:0] p, input logic [31:0] v, input int n);
        etr_master_i.start();
        put({`ETR_SLAVE_ADDR, 1'b0});
        put({3'h0, p});
        for (int i = 0; i < n; i++) begin
            put(v[8*i +: 8]);
        end
        etr_master_i.stop();
    endtask
    task automatic rc(input logic [4:0] p, input int n,
                      input logic [31:0] m, input logic [31:0] e);
        etr_pkg::etr_byte_t b;
        logic [31:0] v;
        v = 32'h0;
        etr_master_i.start();
        put({`ETR_SLAVE_ADDR, 1'b0});
        put({3'h0, p});
        etr_master_i.start();
        put({`ETR_SLAVE_ADDR, 1'b1});
        for (int i = 0; i < n; i++) begin
            etr_master_i.rd_byte(i == n - 1, b);
            v[8*i +: 8] = b;
        end
        etr_master_i.stop();
        check(v & m, e);
    endtask
    task automatic ev(input logic [31:0] a);
        @(posedge clk_sys);
        ev_end <= 1'b1;
        acc_in <= a;
        @(posedge clk_sys);
        ev_end <= 1'b0;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys);
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rc(`ETR_A_CFG, 1, 32'h30, 32'h0);
        $display("test reset done");
        for (int i = 0; i < `ETR_USR_N; i++) begin
            wr(`ETR_A_USR + 5'(i), 32'h30 + i, 1);
        end
        for (int i = 0; i < `ETR_USR_N; i++) begin
            rc(`ETR_A_USR + 5'(i), 1, 32'hff, 32'h30 + i);
        end
        rc(`ETR_A_CLR, 1, 32'hff, 32'h0);
        rc(`ETR_A_CORE, 1, 32'hff, 32'h0);
        rc(`ETR_A_ULOCK, 1, 32'hff, 32'h0);
        $display("test memory done");
        wr(`ETR_A_TRIP, 32'h5, 4);
        rc(`ETR_A_TRIP, 4, 32'hffffffff, 32'h5);
        ev(32'h3);
        check(alarm_act, 1'b1);
        check(alarm_oe, 1'b1);
        wr(`ETR_A_CFG, 32'h02, 1);
        check(alarm_act, 1'b0);
        ev(32'h5);
        check(alarm_act, 1'b1);
        check(alarm_oe, 1'b1);
        wr(`ETR_A_CFG, 32'h08, 1);
        check(alarm_act, 1'b0);
        oe_rises = 0;
        ev(32'h2);
        repeat (300) @(posedge clk_sys);
        check(oe_rises, 32'h4);
        $display("test alarm done");
        wr(`ETR_A_EVT, 32'hffff, 2);
        ev(32'h0);
        check(evt_cnt, 16'h0);
        rc(`ETR_A_CFG, 1, 32'h01, 32'h01);
        wr(`ETR_A_EVT, 32'hffff, 2);
        ev(32'h0);
        check(evt_cnt, 16'hffff);
        $display("test events done");
        ev(32'h9);
        wr(`ETR_A_CLR, 32'h55, 1);
        check(accum, 32'h9);
        wr(`ETR_A_CFG, 32'h04, 1);
        wr(`ETR_A_CLR, 32'h55, 1);
        check(accum, 32'h0);
        check(evt_cnt, 16'h0);
        ev(32'h7);
        wr(`ETR_A_CFG, 32'h80, 1);
        wr(`ETR_A_CLR, 32'h55, 1);
        check(accum, 32'h0);
        $display("test clear done");
        wr(`ETR_A_ULOCK, 32'hf0, 1);
        wr(`ETR_A_USR, 32'h11, 1);
        wr(`ETR_A_ULOCK, 32'hf0, 1);
        rc(`ETR_A_CFG, 1, 32'h10, 32'h0);
        wr(`ETR_A_ULOCK, 32'hf0, 1);
        rc(`ETR_A_CFG, 1, 32'h10, 32'h10);
        wr(`ETR_A_USR, 32'h22, 1);
        rc(`ETR_A_USR, 1, 32'hff, 32'h11);
        wr(`ETR_A_TRIP, 32'h77, 1);
        rc(`ETR_A_TRIP, 1, 32'hff, 32'h77);
        $display("test memory lock done");
        wr(`ETR_A_CORE, 32'haa, 1);
        wr(`ETR_A_CORE, 32'haa, 1);
        rc(`ETR_A_CFG, 1, 32'h20, 32'h20);
        wr(`ETR_A_TRIP, 32'h66, 1);
        rc(`ETR_A_TRIP, 1, 32'hff, 32'h77);
        wr(`ETR_A_CFG, 32'h00, 1);
        rc(`ETR_A_CFG, 1, 32'h80, 32'h80);
        $display("test core lock done");
        give_verdict();
    end
endmodule
bind etr_top etr_top_asserts #(.PULSE_LOW_CYC(PULSE_LOW_CYC),
    .PULSE_HIGH_CYC(PULSE_HIGH_CYC)) etr_top_asserts_i (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_scl(i_scl),
    .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
    .i_alarm_pin(i_alarm_pin), .o_alarm_out(o_alarm_out),
    .o_alarm_oe(o_alarm_oe), .i_event_end(i_event_end),
    .i_accum_value(i_accum_value), .o_accum(o_accum),
    .o_event_count(o_event_count), .o_alarm_active(o_alarm_active),
    .o_clear(o_clear));
